// *** rtl/scs_status_contact.sv ***
// multi-function status contact selector with apb registers and interrupt
`timescale 1ns/1ps
module scs_status_contact
   import scs_pkg::*;
(
   // apb clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [SCS_DATA_W-1:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [SCS_DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // drive conditions and measurements
   input wire scs_cond_s cond,
   input wire scs_meas_s meas,
   // contacts and interrupt
   output logic [SCS_NCH-1:0] contact_closed,
   output logic irq
);
   logic [3:0] sel_r [SCS_NCH];
   scs_cfg_s cfg_r;
   logic [SCS_FREQ_W-1:0] ot_level_r;
   logic [SCS_FREQ_W-1:0] ot_time_r;
   logic [SCS_FREQ_W-1:0] ot_cnt_r;
   logic overtorque_r;
   logic [SCS_NCH-1:0] closed_w;
   logic [SCS_NCH-1:0] closed_d_r;
   logic [SCS_NCH-1:0] irq_st_r;
   logic [SCS_NCH-1:0] irq_mask_r;
   logic [SCS_NCH-1:0] irq_set;
   logic [SCS_NCH-1:0] irq_clr;
   logic acc;
   logic wr;
   logic addr_ok;
   logic [SCS_DATA_W-1:0] rd_nxt;
   logic [SCS_DATA_W-1:0] wmask;

   // zero wait states: every access completes in its first access cycle
   assign acc = psel & penable;
   assign wr = acc & pwrite;

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         wmask[i*8 +: 8] = {8{pstrb[i]}};
      end
   end

   always_comb begin
      addr_ok = 1'b1;
      rd_nxt = '0;
      case (paddr)
         SCS_OFF_SEL: begin
            rd_nxt[SCS_SEL0_LSB +: 4] = sel_r[0];
            rd_nxt[SCS_SEL1_LSB +: 4] = sel_r[1];
         end
         SCS_OFF_LVL1: rd_nxt[SCS_FREQ_W-1:0] = cfg_r.freq_detect_level_one;
         SCS_OFF_LVL2: rd_nxt[SCS_FREQ_W-1:0] = cfg_r.freq_detect_level_two;
         SCS_OFF_WIDTH: rd_nxt[SCS_FREQ_W-1:0] = cfg_r.agreed_freq_width;
         SCS_OFF_POINT: rd_nxt[SCS_FREQ_W-1:0] = cfg_r.agreed_freq_point;
         SCS_OFF_OTLVL: rd_nxt[SCS_FREQ_W-1:0] = ot_level_r;
         SCS_OFF_OTTIME: rd_nxt[SCS_FREQ_W-1:0] = ot_time_r;
         SCS_OFF_STAT: begin
            rd_nxt[SCS_NCH-1:0] = closed_d_r;
            rd_nxt[SCS_NCH] = overtorque_r;
         end
         SCS_OFF_IRQ_ST: rd_nxt[SCS_NCH-1:0] = irq_st_r;
         SCS_OFF_IRQ_MASK: rd_nxt[SCS_NCH-1:0] = irq_mask_r;
         default: addr_ok = 1'b0;
      endcase
   end

   // bus answer registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~addr_ok;
         if (psel && !penable && !pwrite) begin
            prdata <= rd_nxt;
         end
      end
   end

   // setting codes; software writes F to parked contacts
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < SCS_NCH; i++) begin
            sel_r[i] <= SCS_SEL_RST;
         end
      end else if (wr && pready && paddr == SCS_OFF_SEL && pstrb[0]) begin
         sel_r[0] <= pwdata[SCS_SEL0_LSB +: 4];
         sel_r[1] <= pwdata[SCS_SEL1_LSB +: 4];
      end
   end

   // frequency and torque settings
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_r <= '{default: SCS_FREQ_RST};
         ot_level_r <= SCS_FREQ_RST;
         ot_time_r <= SCS_OTTIME_RST;
      end else if (wr && pready) begin
         case (paddr)
            SCS_OFF_LVL1: cfg_r.freq_detect_level_one <=
               (cfg_r.freq_detect_level_one & ~wmask[15:0]) | (pwdata[15:0] & wmask[15:0]);
            SCS_OFF_LVL2: cfg_r.freq_detect_level_two <=
               (cfg_r.freq_detect_level_two & ~wmask[15:0]) | (pwdata[15:0] & wmask[15:0]);
            SCS_OFF_WIDTH: cfg_r.agreed_freq_width <=
               (cfg_r.agreed_freq_width & ~wmask[15:0]) | (pwdata[15:0] & wmask[15:0]);
            SCS_OFF_POINT: cfg_r.agreed_freq_point <=
               (cfg_r.agreed_freq_point & ~wmask[15:0]) | (pwdata[15:0] & wmask[15:0]);
            SCS_OFF_OTLVL: ot_level_r <=
               (ot_level_r & ~wmask[15:0]) | (pwdata[15:0] & wmask[15:0]);
            SCS_OFF_OTTIME: ot_time_r <=
               (ot_time_r & ~wmask[15:0]) | (pwdata[15:0] & wmask[15:0]);
            default: begin
            end
         endcase
      end
   end

   // overtorque: torque above level for ot_time + 1 consecutive cycles
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ot_cnt_r <= '0;
         overtorque_r <= 1'b0;
      end else if (meas.torque > ot_level_r) begin
         if (ot_cnt_r >= ot_time_r) begin
            overtorque_r <= 1'b1;
         end else begin
            ot_cnt_r <= ot_cnt_r + 16'h0001;
         end
      end else begin
         ot_cnt_r <= '0;
         overtorque_r <= 1'b0;
      end
   end

   genvar g;
   generate
      for (g = 0; g < SCS_NCH; g++) begin : g_ch
         scs_contact_sel u_sel (
            .pclk(pclk),
            .presetn(presetn),
            .code(sel_r[g]),
            .cond(cond),
            .meas(meas),
            .cfg(cfg_r),
            .overtorque(overtorque_r),
            .closed_r(closed_w[g])
         );
      end
   endgenerate

   assign contact_closed = closed_w;

   // interrupt: any contact change is an event; set beats clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         closed_d_r <= '0;
      end else begin
         closed_d_r <= closed_w;
      end
   end

   assign irq_set = closed_w ^ closed_d_r;
   assign irq_clr = (wr && pready && paddr == SCS_OFF_IRQ_ST && pstrb[0]) ?
                    pwdata[SCS_NCH-1:0] : '0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_st_r <= SCS_IRQ_RST;
         irq_mask_r <= SCS_IRQ_RST;
      end else begin
         irq_st_r <= (irq_st_r & ~irq_clr) | irq_set;
         if (wr && pready && paddr == SCS_OFF_IRQ_MASK && pstrb[0]) begin
            irq_mask_r <= pwdata[SCS_NCH-1:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |((irq_st_r & ~irq_clr | irq_set) & irq_mask_r);
      end
   end
endmodule

// *** rtl/scs_pkg.sv ***
// package for the status contact selector: register map, codes, layouts
package scs_pkg;
   localparam int unsigned SCS_DATA_W = 32;
   localparam int unsigned SCS_FREQ_W = 16;
   localparam int unsigned SCS_NCH = 2;
   // register byte offsets
   localparam logic [7:0] SCS_OFF_SEL = 8'h00;
   localparam logic [7:0] SCS_OFF_LVL1 = 8'h04;
   localparam logic [7:0] SCS_OFF_LVL2 = 8'h08;
   localparam logic [7:0] SCS_OFF_WIDTH = 8'h0C;
   localparam logic [7:0] SCS_OFF_POINT = 8'h10;
   localparam logic [7:0] SCS_OFF_OTLVL = 8'h14;
   localparam logic [7:0] SCS_OFF_OTTIME = 8'h18;
   localparam logic [7:0] SCS_OFF_STAT = 8'h1C;
   localparam logic [7:0] SCS_OFF_IRQ_ST = 8'h20;
   localparam logic [7:0] SCS_OFF_IRQ_MASK = 8'h24;
   // field positions in the select register
   localparam int unsigned SCS_SEL0_LSB = 0;
   localparam int unsigned SCS_SEL1_LSB = 4;
   // reset values
   localparam logic [3:0] SCS_SEL_RST = 4'hF;
   localparam logic [SCS_FREQ_W-1:0] SCS_FREQ_RST = 16'h0000;
   localparam logic [SCS_FREQ_W-1:0] SCS_OTTIME_RST = 16'h0001;
   localparam logic [1:0] SCS_IRQ_RST = 2'h0;
   // setting codes
   localparam logic [3:0] SCS_CODE_RUN = 4'h0;
   localparam logic [3:0] SCS_CODE_ZERO = 4'h1;
   localparam logic [3:0] SCS_CODE_AGREE_REF = 4'h2;
   localparam logic [3:0] SCS_CODE_AGREE_PT = 4'h3;
   localparam logic [3:0] SCS_CODE_FDET1 = 4'h4;
   localparam logic [3:0] SCS_CODE_FDET2 = 4'h5;
   localparam logic [3:0] SCS_CODE_READY = 4'h6;
   localparam logic [3:0] SCS_CODE_UV = 4'h7;
   localparam logic [3:0] SCS_CODE_BLOCK = 4'h8;
   localparam logic [3:0] SCS_CODE_REF_OP = 4'h9;
   localparam logic [3:0] SCS_CODE_CMD_KEY = 4'hA;
   localparam logic [3:0] SCS_CODE_OVERTQ = 4'hB;
   localparam logic [3:0] SCS_CODE_REF_LOSS = 4'hC;
   localparam logic [3:0] SCS_CODE_UNUSED_D = 4'hD;
   localparam logic [3:0] SCS_CODE_FAULT = 4'hE;
   localparam logic [3:0] SCS_CODE_UNUSED_F = 4'hF;

   // internal drive conditions, sampled on pclk
   typedef struct packed {
      logic run_forward_cmd;
      logic run_reverse_cmd;
      logic output_active;
      logic ramping;
      logic drive_ready;
      logic undervoltage_flag;
      logic output_blocked;
      logic ref_from_operator;
      logic cmd_from_keypad;
      logic ref_lost;
      logic major_fault;
      logic operator_watchdog_fault;
      logic operator_link_fault;
   } scs_cond_s;

   typedef struct packed {
      logic [SCS_FREQ_W-1:0] out_freq;
      logic [SCS_FREQ_W-1:0] freq_ref;
      logic [SCS_FREQ_W-1:0] min_freq;
      logic [SCS_FREQ_W-1:0] torque;
   } scs_meas_s;

   // programmed settings handed to each contact selector
   typedef struct packed {
      logic [SCS_FREQ_W-1:0] freq_detect_level_one;
      logic [SCS_FREQ_W-1:0] freq_detect_level_two;
      logic [SCS_FREQ_W-1:0] agreed_freq_width;
      logic [SCS_FREQ_W-1:0] agreed_freq_point;
   } scs_cfg_s;
endpackage

// *** rtl/scs_contact_sel.sv ***
// one multi-function contact: code decode and registered contact
`timescale 1ns/1ps
module scs_contact_sel
   import scs_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // selection and conditions
   input wire logic [3:0] code,
   input wire scs_cond_s cond,
   input wire scs_meas_s meas,
   input wire scs_cfg_s cfg,
   input wire logic overtorque,
   // contact
   output logic closed_r
);
   logic closed_nxt;
   logic [SCS_FREQ_W:0] ref_lo;
   logic [SCS_FREQ_W:0] ref_hi;
   logic [SCS_FREQ_W:0] pt_lo;
   logic [SCS_FREQ_W:0] pt_hi;
   logic [SCS_FREQ_W:0] fo;

   // one extra bit so the upper window edges do not wrap; the lower edges clamp at zero
   always_comb begin
      fo = {1'b0, meas.out_freq};
      ref_hi = {1'b0, meas.freq_ref} + {1'b0, cfg.agreed_freq_width};
      pt_hi = {1'b0, cfg.agreed_freq_point} + {1'b0, cfg.agreed_freq_width};
      if (meas.freq_ref > cfg.agreed_freq_width) begin
         ref_lo = {1'b0, meas.freq_ref - cfg.agreed_freq_width};
      end else begin
         ref_lo = '0;
      end
      if (cfg.agreed_freq_point > cfg.agreed_freq_width) begin
         pt_lo = {1'b0, cfg.agreed_freq_point - cfg.agreed_freq_width};
      end else begin
         pt_lo = '0;
      end
   end

   always_comb begin
      case (code)
         SCS_CODE_RUN: begin
            closed_nxt = cond.run_forward_cmd | cond.run_reverse_cmd
                         | cond.output_active;
         end
         SCS_CODE_ZERO: begin
            closed_nxt = meas.out_freq < meas.min_freq;
         end
         SCS_CODE_AGREE_REF: begin
            closed_nxt = (fo >= ref_lo) && (fo <= ref_hi);
         end
         SCS_CODE_AGREE_PT: begin
            closed_nxt = !cond.ramping && (fo >= pt_lo) && (fo <= pt_hi);
         end
         SCS_CODE_FDET1: begin
            closed_nxt = meas.out_freq <= cfg.freq_detect_level_one;
         end
         SCS_CODE_FDET2: begin
            closed_nxt = meas.out_freq >= cfg.freq_detect_level_two;
         end
         SCS_CODE_READY: begin
            closed_nxt = cond.drive_ready;
         end
         SCS_CODE_UV: begin
            closed_nxt = cond.undervoltage_flag;
         end
         SCS_CODE_BLOCK: begin
            closed_nxt = cond.output_blocked;
         end
         SCS_CODE_REF_OP: begin
            closed_nxt = cond.ref_from_operator;
         end
         SCS_CODE_CMD_KEY: begin
            closed_nxt = cond.cmd_from_keypad;
         end
         SCS_CODE_OVERTQ: begin
            closed_nxt = overtorque;
         end
         SCS_CODE_REF_LOSS: begin
            closed_nxt = cond.ref_lost;
         end
         SCS_CODE_FAULT: begin
            // the drive cannot steer the contact through these two faults
            closed_nxt = cond.major_fault & ~cond.operator_watchdog_fault
                         & ~cond.operator_link_fault;
         end
         SCS_CODE_UNUSED_D: begin
            closed_nxt = 1'b0;
         end
         default: begin
            closed_nxt = 1'b0;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         closed_r <= 1'b0;
      end else begin
         closed_r <= closed_nxt;
      end
   end
endmodule

// *** tb/scs_status_contact_assertions.sv ***
// assertion checker for the status contact selector
`timescale 1ns/1ps
module scs_status_contact_assertions
   import scs_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [SCS_DATA_W-1:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic pready,
   input wire logic pslverr,
   // drive side
   input wire scs_cond_s cond,
   input wire logic [SCS_NCH-1:0] contact_closed
);
   logic [3:0] sel_r;
   logic fault_ok;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   assign fault_ok = cond.major_fault && !cond.operator_watchdog_fault
      && !cond.operator_link_fault;
   // shadow of the contact 0 code, taken from completed writes only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_r <= SCS_SEL_RST;
      end else if (psel && penable && pready && pwrite && paddr == SCS_OFF_SEL && pstrb[0]) begin
         sel_r <= pwdata[3:0];
      end
   end
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_code(logic [3:0] c);
      sel_r == c;
   endsequence
   property p_apb;
      s_setup |=> pready;
   endproperty
   property p_err;
      pslverr |-> pready;
   endproperty
   property p_ready;
      s_code(SCS_CODE_READY) |=> contact_closed[0] == $past(cond.drive_ready);
   endproperty
   property p_uv;
      s_code(SCS_CODE_UV) |=> contact_closed[0] == $past(cond.undervoltage_flag);
   endproperty
   property p_block;
      s_code(SCS_CODE_BLOCK) |=> contact_closed[0] == $past(cond.output_blocked);
   endproperty
   property p_refop;
      s_code(SCS_CODE_REF_OP) |=> contact_closed[0] == $past(cond.ref_from_operator);
   endproperty
   property p_key;
      s_code(SCS_CODE_CMD_KEY) |=> contact_closed[0] == $past(cond.cmd_from_keypad);
   endproperty
   property p_loss;
      s_code(SCS_CODE_REF_LOSS) |=> contact_closed[0] == $past(cond.ref_lost);
   endproperty
   property p_fault;
      s_code(SCS_CODE_FAULT) |=> contact_closed[0] == $past(fault_ok);
   endproperty
   property p_unused;
      s_code(SCS_CODE_UNUSED_D) or s_code(SCS_CODE_UNUSED_F) |=> !contact_closed[0];
   endproperty
   a_apb: assert property (p_apb) else $error("no ready after setup");
   a_err: assert property (p_err) else $error("error without ready");
   a_ready: assert property (p_ready) else $error("ready contact wrong");
   a_uv: assert property (p_uv) else $error("undervoltage contact wrong");
   a_block: assert property (p_block) else $error("blocked contact wrong");
   a_refop: assert property (p_refop) else $error("operator ref contact wrong");
   a_key: assert property (p_key) else $error("keypad contact wrong");
   a_loss: assert property (p_loss) else $error("ref loss contact wrong");
   a_fault: assert property (p_fault) else $error("fault contact wrong");
   a_unused: assert property (p_unused) else $error("unused code closed");
endmodule
bind scs_status_contact scs_status_contact_assertions u_chk (.pclk, .presetn, .psel,
   .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .pslverr, .cond, .contact_closed);

// *** tb/scs_relay_model.sv ***
// relay coil model standing behind the contact outputs
`timescale 1ns/1ps
module scs_relay_model
   import scs_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // coil drive and sensed contact
   input wire logic [SCS_NCH-1:0] coil,
   output logic [SCS_NCH-1:0] sense
);
   // armature settles one cycle after the coil changes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sense <= '0;
      end else begin
         sense <= coil;
      end
   end
endmodule

// *** tb/tb.sv ***
// testbench for the status contact selector
`timescale 1ns/1ps
module tb;
   import scs_pkg::*;
   logic pclk = 0;
   logic presetn = 0;
   logic psel = 0;
   logic penable = 0;
   logic pwrite = 0;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [3:0] pstrb = 4'hF;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic irq;
   logic [1:0] contact;
   logic [1:0] relay;
   scs_cond_s cond = '0;
   scs_meas_s meas = '0;
   int error_cnt = 0;
   int comparisons = 0;
   logic [31:0] rd;
   logic er;
   always #20 pclk = ~pclk;
   scs_status_contact u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cond(cond), .meas(meas),
      .contact_closed(contact), .irq(irq));
   scs_relay_model u_relay (.pclk(pclk), .presetn(presetn), .coil(contact), .sense(relay));
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) error_cnt++;
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task wt(input int n);
      repeat (n) @(posedge pclk);
      @(negedge pclk);
   endtask
   function automatic scs_cond_s mk(input logic [3:0] c);
      scs_cond_s s;
      s = '0;
      case (c)
         4'h0: s.run_reverse_cmd = 1;
         4'h6: s.drive_ready = 1;
         4'h7: s.undervoltage_flag = 1;
         4'h8: s.output_blocked = 1;
         4'h9: s.ref_from_operator = 1;
         4'hA: s.cmd_from_keypad = 1;
         4'hC: s.ref_lost = 1;
         default: s.major_fault = 1;
      endcase
      return s;
   endfunction
   task t_reset;
      apb(0, SCS_OFF_SEL, '0);
      chk("sel_rst", rd, 32'h0000_00FF);
      apb(0, SCS_OFF_OTTIME, '0);
      chk("ottime_rst", rd, 32'h0000_0001);
      chk("contact_rst", contact, '0);
   endtask
   task t_flags;
      logic [3:0] cl[8];
      cl = '{4'h0, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hC, 4'hE};
      foreach (cl[i]) begin
         apb(1, SCS_OFF_SEL, {24'h0, cl[i], cl[i]});
         @(posedge pclk);
         cond <= mk(cl[i]);
         wt(3);
         chk("relay_on", relay, 2'b11);
         @(posedge pclk);
         cond <= (cl[i] == 4'h0) ? '0 : ~mk(cl[i]);
         wt(3);
         chk("relay_off", relay, 2'b00);
      end
      @(posedge pclk);
      cond <= '{major_fault: 1, operator_watchdog_fault: 1, default: 0};
      wt(3);
      chk("fault_wd", contact, 2'b00);
      @(posedge pclk);
      cond <= '{major_fault: 1, operator_link_fault: 1, default: 0};
      wt(3);
      chk("fault_link", contact, 2'b00);
      apb(1, SCS_OFF_SEL, 32'h0000_00FD);
      @(posedge pclk);
      cond <= '1;
      wt(3);
      chk("code_d", contact, 2'b00);
   endtask
   task mc(input logic [15:0] o, input logic [15:0] m, input logic [1:0] e);
      @(posedge pclk);
      meas <= '{out_freq: o, min_freq: m, default: 0};
      wt(3);
      chk("freq", contact, e);
   endtask
   task mw(input logic [15:0] o, input logic [15:0] r, input logic rp, input logic [1:0] e);
      @(posedge pclk);
      meas <= '{out_freq: o, freq_ref: r, default: 0};
      cond <= '{ramping: rp, default: 0};
      wt(3);
      chk("agree", contact, e);
   endtask
   task t_freq;
      @(posedge pclk);
      cond <= '0;
      apb(1, SCS_OFF_LVL1, 32'h0000_0064);
      apb(1, SCS_OFF_LVL2, 32'h0000_00C8);
      apb(1, SCS_OFF_SEL, 32'h0000_0054);
      mc(16'h0064, '0, 2'b01);
      mc(16'h0065, '0, 2'b00);
      mc(16'h00C8, '0, 2'b10);
      apb(1, SCS_OFF_SEL, 32'h0000_0011);
      mc(16'h0064, 16'h0065, 2'b11);
      mc(16'h0064, 16'h0064, 2'b00);
      // width 10, point 50: contact 0 follows the reference, contact 1 the point
      apb(1, SCS_OFF_WIDTH, 32'h0000_000A);
      apb(1, SCS_OFF_POINT, 32'h0000_0032);
      apb(1, SCS_OFF_SEL, 32'h0000_0032);
      mw(16'h005A, 16'h0064, 1'b0, 2'b01);
      mw(16'h006E, 16'h0064, 1'b0, 2'b01);
      mw(16'h006F, 16'h0064, 1'b0, 2'b00);
      mw(16'h0000, 16'h0005, 1'b0, 2'b01);
      mw(16'h0028, 16'h0064, 1'b0, 2'b10);
      mw(16'h0027, 16'h0064, 1'b0, 2'b00);
      mw(16'h003C, 16'h0064, 1'b0, 2'b10);
      mw(16'h003D, 16'h0064, 1'b0, 2'b00);
      mw(16'h0032, 16'h0064, 1'b1, 2'b00);
   endtask
   task t_ot;
      apb(1, SCS_OFF_OTLVL, 32'h0000_0032);
      apb(1, SCS_OFF_SEL, 32'h0000_00FB);
      @(posedge pclk);
      meas <= '{torque: 16'h0033, default: 0};
      wt(5);
      chk("ot_on", contact, 2'b01);
      apb(0, SCS_OFF_STAT, '0);
      chk("stat", rd, 32'h0000_0005);
      @(posedge pclk);
      meas <= '{torque: 16'h0032, default: 0};
      wt(5);
      chk("ot_off", contact, 2'b00);
      // qualifying time 4: flag after five edges above level, contact one edge later
      apb(1, SCS_OFF_OTTIME, 32'h0000_0004);
      @(posedge pclk);
      meas <= '{torque: 16'h0033, default: 0};
      wt(5);
      chk("ot_wait", contact, 2'b00);
      wt(1);
      chk("ot_late", contact, 2'b01);
   endtask
   task t_irq;
      @(posedge pclk);
      cond <= '0;
      apb(1, SCS_OFF_SEL, 32'h0000_00F6);
      wt(3);
      apb(1, SCS_OFF_IRQ_ST, 32'h0000_0003);
      @(posedge pclk);
      cond <= mk(4'h6);
      wt(4);
      chk("irq_masked", irq, 1'b0);
      apb(0, SCS_OFF_IRQ_ST, '0);
      chk("irq_st", rd, 32'h0000_0001);
      apb(1, SCS_OFF_IRQ_MASK, 32'h0000_0001);
      wt(2);
      chk("irq_on", irq, 1'b1);
      apb(1, SCS_OFF_IRQ_ST, 32'h0000_0001);
      wt(2);
      chk("irq_clr", irq, 1'b0);
      apb(0, 8'h40, '0);
      chk("unmapped_err", er, 1'b1);
      chk("unmapped_rd", rd, '0);
   endtask
   task print_verdict;
      $display("comparisons %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1;
      t_reset;
      t_flags;
      t_freq;
      t_ot;
      t_irq;
      print_verdict;
   end
   // watchdog: the whole run needs well under two thousand cycles
   initial begin
      repeat (20000) @(posedge pclk);
      error_cnt++;
      print_verdict;
   end
endmodule
